// file: hdl/pgd_pkg.sv
package pgd_pkg;
	// ----------------------------------------------------------------
	// Register indices, byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [7:0] PGD_REG_CTRL = 8'hE0;
	localparam logic [7:0] PGD_REG_IRQ = 8'hE1;
	localparam logic [7:0] PGD_REG_LEN = 8'hE2;
	localparam logic [7:0] PGD_REG_TAP = 8'hE3;
	localparam logic [7:0] PGD_REG_EINS = 8'hE4;
	localparam logic [7:0] PGD_REG_SEED0 = 8'hE8;
	localparam logic [7:0] PGD_REG_SEED3 = 8'hEB;
	localparam logic [7:0] PGD_REG_DET0 = 8'hEC;
	localparam logic [7:0] PGD_REG_DET3 = 8'hEF;
	localparam logic [7:0] PGD_REG_UPDATE = 8'hF8;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int PGD_CTRL_SEL_HI = 7;
	localparam int PGD_CTRL_SEL_LO = 6;
	localparam int PGD_CTRL_QRSS = 5;
	localparam int PGD_CTRL_PTYPE = 4;
	localparam int PGD_CTRL_TRANSMIT_INVERT = 3;
	localparam int PGD_CTRL_RECEIVE_INVERT = 2;
	localparam int PGD_CTRL_AUTO = 1;
	localparam int PGD_CTRL_MANS = 0;
	localparam int PGD_IEN_SYNC = 2;
	localparam int PGD_IEN_BERR = 1;
	localparam int PGD_IEN_XFER = 0;
	localparam int PGD_IRQ_EN_LO = 5;
	localparam int PGD_EINS_EVENT = 3;
	// ----------------------------------------------------------------
	// Reset values and timing counts
	// ----------------------------------------------------------------
	localparam logic [7:0] PGD_CTRL_RST = 8'h02;
	localparam logic [5:0] PGD_SYNC_BITS = 6'h30;
	localparam logic [5:0] PGD_WIN_BITS = 6'h30;
	localparam logic [3:0] PGD_LOSS_ERRS = 4'hA;
	localparam int PGD_ZRUN = 14;
	localparam int PGD_BIT_DIV = 4;

	// Top count of the insertion counter, one error per top+1 bits
	function automatic logic [23:0] pgd_rate_top(input logic [2:0] code);
		unique case (code)
			3'h1: pgd_rate_top = 24'h000009;
			3'h2: pgd_rate_top = 24'h000063;
			3'h3: pgd_rate_top = 24'h0003E7;
			3'h4: pgd_rate_top = 24'h00270F;
			3'h5: pgd_rate_top = 24'h01869F;
			3'h6: pgd_rate_top = 24'h0F423F;
			3'h7: pgd_rate_top = 24'h98967F;
			default: pgd_rate_top = 24'h000000;
		endcase
	endfunction : pgd_rate_top
endpackage : pgd_pkg

// file: hdl/pgd_pattern_step.sv
`timescale 1ns/10ps
module pgd_pattern_step #(
	parameter int WIDTH = 32,
	parameter int ZRUN = 14
) (
	input wire logic [WIDTH-1:0] state_in, // Shift register contents
	input wire logic [4:0] len_in, // Length field, last stage index
	input wire logic [4:0] tap_in, // Tap field, tap stage index
	input wire logic rep_in, // Repetitive pattern selected
	input wire logic qrss_in, // Zero suppression enabled
	output logic bit_out, // Pattern bit after suppression
	output logic [WIDTH-1:0] next_out // State after one bit
);
	logic raw;

	if (WIDTH < 32 || ZRUN > WIDTH) begin : g_bad_width
		$error("pgd_pattern_step: WIDTH must be 32 or more and cover ZRUN");
	end

	always_comb begin
		// Repetitive mode rotates the programmed length
		raw = rep_in ? state_in[len_in] : state_in[len_in] ^ state_in[tap_in];
		// Forced one keeps the line from a long run of zeros
		bit_out = raw | (qrss_in & (state_in[ZRUN-1:0] == '0));
		next_out = {state_in[WIDTH-2:0], raw};
	end
endmodule : pgd_pattern_step

// file: hdl/pgd_pattern_gen_detect.sv
`timescale 1ns/10ps
module pgd_pattern_gen_detect import pgd_pkg::*; #(
	parameter int BIT_DIV = PGD_BIT_DIV
) (
	input wire logic mclk_in, // 10 MHz clock
	input wire logic rst_b_in, // Asynchronous reset, active low
	input wire logic psel_in, // APB select
	input wire logic penable_in, // APB enable
	input wire logic pwrite_in, // APB write
	input wire logic [9:0] paddr_in, // APB byte address
	input wire logic [31:0] pwdata_in, // APB write data
	output logic [31:0] prdata_out, // APB read data
	output logic pready_out, // APB ready
	output logic pslverr_out, // APB error on unmapped address
	input wire logic rx_data_in, // Received line bit
	output logic tx_data_out, // Transmitted line bit
	output logic bit_en_out, // One-cycle bit rate strobe
	output logic irq_out // Interrupt request, active high
);
	typedef struct packed {
		logic rx_meta;
		logic rx_sync;
		logic [7:0] div_cnt;
		logic [7:0] ctrl;
		logic [2:0] ien;
		logic [4:0] len;
		logic [4:0] tap;
		logic [3:0] eins;
		logic [31:0] seed;
		logic [31:0] gen;
		logic [31:0] det;
		logic [31:0] rxpat;
		logic [31:0] bitcnt;
		logic [31:0] errcnt;
		logic [31:0] hold_pat;
		logic [31:0] hold_err;
		logic [31:0] hold_bit;
		logic sync;
		logic sync_f;
		logic be_f;
		logic xfer_f;
		logic ovr_f;
		logic [5:0] match_cnt;
		logic [5:0] win_cnt;
		logic [3:0] win_err;
		logic mans_d;
		logic event_d;
		logic ins_pend;
		logic [23:0] rate_cnt;
		logic tx_bit;
		logic [31:0] prdata;
	} pgd_state_s;

	pgd_state_s r;
	pgd_state_s n;
	logic bit_en, acc, wr, rd_irq, cap, hit, resync, ev_edge, rate_hit, err_ins;
	logic rxb, d_err, g_bit, d_bit, loss;
	logic [7:0] idx;
	logic [7:0] rdval;
	logic [31:0] g_next, d_next, sel_val;
	logic [3:0] win_err_new;

	if (BIT_DIV < 1 || BIT_DIV > 256) begin : g_bad_div
		$error("pgd_pattern_gen_detect: BIT_DIV must be 1 to 256");
	end

	pgd_pattern_step #(.WIDTH(32), .ZRUN(PGD_ZRUN)) u_gen_step (
		.state_in(r.gen),
		.len_in(r.len),
		.tap_in(r.tap),
		.rep_in(r.ctrl[PGD_CTRL_PTYPE]),
		.qrss_in(r.ctrl[PGD_CTRL_QRSS]),
		.bit_out(g_bit),
		.next_out(g_next)
	);

	pgd_pattern_step #(.WIDTH(32), .ZRUN(PGD_ZRUN)) u_det_step (
		.state_in(r.det),
		.len_in(r.len),
		.tap_in(r.tap),
		.rep_in(r.ctrl[PGD_CTRL_PTYPE]),
		.qrss_in(r.ctrl[PGD_CTRL_QRSS]),
		.bit_out(d_bit),
		.next_out(d_next)
	);

	// ----------------------------------------------------------------
	// Bus decode and read mux
	// ----------------------------------------------------------------
	assign idx = paddr_in[9:2];
	assign acc = psel_in & penable_in;
	assign hit = (idx >= PGD_REG_CTRL && idx <= PGD_REG_EINS) ||
		(idx >= PGD_REG_SEED0 && idx <= PGD_REG_DET3) || idx == PGD_REG_UPDATE;
	assign wr = acc & pwrite_in & hit;
	assign rd_irq = acc & ~pwrite_in & (idx == PGD_REG_IRQ);
	assign cap = wr & ((idx >= PGD_REG_DET0 && idx <= PGD_REG_DET3) || idx == PGD_REG_UPDATE);
	// Read data is registered in the setup cycle, so no wait state is needed
	assign pready_out = 1'b1;
	assign pslverr_out = acc & ~hit;
	assign prdata_out = r.prdata;
	assign tx_data_out = r.tx_bit;
	assign bit_en_out = bit_en;
	assign irq_out = |(r.ien & {r.sync_f, r.be_f, r.xfer_f});

	always_comb begin
		unique case (r.ctrl[PGD_CTRL_SEL_HI:PGD_CTRL_SEL_LO])
			2'h2: sel_val = r.hold_err;
			2'h3: sel_val = r.hold_bit;
			default: sel_val = r.hold_pat;
		endcase
		unique case (idx)
			PGD_REG_CTRL: rdval = r.ctrl;
			PGD_REG_IRQ: rdval = {r.ien, r.sync, r.sync_f, r.be_f, r.xfer_f, r.ovr_f};
			PGD_REG_LEN: rdval = {3'h0, r.len};
			PGD_REG_TAP: rdval = {3'h0, r.tap};
			PGD_REG_EINS: rdval = {4'h0, r.eins};
			8'hE8, 8'hE9, 8'hEA, 8'hEB: rdval = r.seed[8*idx[1:0] +: 8];
			8'hEC, 8'hED, 8'hEE, 8'hEF: rdval = sel_val[8*idx[1:0] +: 8];
			default: rdval = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		n = r;
		bit_en = r.div_cnt == 8'(BIT_DIV - 1);
		n.div_cnt = bit_en ? 8'h00 : r.div_cnt + 8'h01;
		n.rx_meta = rx_data_in;
		n.rx_sync = r.rx_meta;
		if (psel_in & ~penable_in & ~pwrite_in) begin
			n.prdata = {24'h000000, rdval};
		end
		if (wr) begin
			unique case (idx)
				PGD_REG_CTRL: n.ctrl = pwdata_in[7:0];
				PGD_REG_IRQ: n.ien = pwdata_in[7:PGD_IRQ_EN_LO];
				PGD_REG_LEN: n.len = pwdata_in[4:0];
				PGD_REG_TAP: n.tap = pwdata_in[4:0];
				PGD_REG_EINS: n.eins = pwdata_in[3:0];
				8'hE8, 8'hE9, 8'hEA, 8'hEB: n.seed[8*idx[1:0] +: 8] = pwdata_in[7:0];
				default: n.ctrl = r.ctrl;
			endcase
		end

		// Edge detectors run on the stored control bits
		n.mans_d = r.ctrl[PGD_CTRL_MANS];
		n.event_d = r.eins[PGD_EINS_EVENT];
		resync = r.ctrl[PGD_CTRL_MANS] & ~r.mans_d;
		ev_edge = r.eins[PGD_EINS_EVENT] & ~r.event_d;

		// Generator with error insertion
		rate_hit = (r.eins[2:0] != 3'h0) && (r.rate_cnt == pgd_rate_top(r.eins[2:0]));
		err_ins = r.ins_pend | rate_hit;
		n.ins_pend = ev_edge | (r.ins_pend & ~bit_en);
		if (bit_en) begin
			n.gen = g_next;
			n.tx_bit = g_bit ^ r.ctrl[PGD_CTRL_TRANSMIT_INVERT] ^ err_ins;
			if (r.eins[2:0] == 3'h0 || rate_hit) begin
				n.rate_cnt = 24'h000000;
			end else begin
				n.rate_cnt = r.rate_cnt + 24'h000001;
			end
		end
		if (wr && idx == PGD_REG_SEED3) begin
			n.gen = {pwdata_in[7:0], r.seed[23:0]};
		end

		// Detector
		rxb = r.rx_sync ^ r.ctrl[PGD_CTRL_RECEIVE_INVERT];
		d_err = rxb != d_bit;
		win_err_new = (d_err && r.win_err != 4'hF) ? r.win_err + 4'h1 : r.win_err;
		loss = r.ctrl[PGD_CTRL_AUTO] && win_err_new >= PGD_LOSS_ERRS;
		if (bit_en) begin
			n.rxpat = {r.rxpat[30:0], rxb};
			if (!r.sync) begin
				// Search: load received bits so the register self-aligns
				n.det = {r.det[30:0], rxb};
				n.match_cnt = d_err ? 6'h00 : r.match_cnt + 6'h01;
				if (!d_err && r.match_cnt == PGD_SYNC_BITS - 6'h01) begin
					n.sync = 1'b1;
					n.match_cnt = 6'h00;
				end
				n.win_cnt = 6'h00;
				n.win_err = 4'h0;
			end else begin
				n.det = d_next;
				if (r.bitcnt != 32'hFFFFFFFF) begin
					n.bitcnt = r.bitcnt + 32'h00000001;
				end
				if (d_err && r.errcnt != 32'hFFFFFFFF) begin
					n.errcnt = r.errcnt + 32'h00000001;
				end
				n.win_cnt = r.win_cnt + 6'h01;
				n.win_err = win_err_new;
				if (r.win_cnt == PGD_WIN_BITS - 6'h01) begin
					n.win_cnt = 6'h00;
					n.win_err = 4'h0;
					n.sync = ~loss;
				end
			end
		end
		if (resync) begin
			n.sync = 1'b0;
			n.match_cnt = 6'h00;
		end

		// Accumulation capture; counters restart from zero
		if (cap) begin
			n.hold_pat = r.rxpat;
			n.hold_err = r.errcnt;
			n.hold_bit = r.bitcnt;
			n.bitcnt = 32'h00000000;
			n.errcnt = 32'h00000000;
		end

		// Flags: read clears only what the read returned, so set wins
		if (rd_irq) begin
			n.sync_f = r.sync_f & ~r.prdata[3];
			n.be_f = r.be_f & ~r.prdata[2];
			n.xfer_f = r.xfer_f & ~r.prdata[1];
			n.ovr_f = r.ovr_f & ~r.prdata[0];
		end
		n.sync_f = n.sync_f | (n.sync != r.sync);
		n.be_f = n.be_f | (bit_en & r.sync & d_err);
		n.xfer_f = n.xfer_f | cap;
		n.ovr_f = n.ovr_f | (cap & r.xfer_f);
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			r <= '0;
			r.ctrl <= PGD_CTRL_RST;
		end else begin
			r <= n;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);

	a_irq_xfer_gate: assert property ($rose(r.xfer_f) && r.ien[PGD_IEN_XFER] |-> irq_out)
		else $error("transfer flag with enable did not raise interrupt");
	a_capture_sets: assert property (cap |=> r.xfer_f && r.bitcnt == 32'h0 && r.errcnt == 32'h0)
		else $error("capture did not set transfer flag and clear counters");
	a_overrun_set: assert property (cap && r.xfer_f |=> r.ovr_f)
		else $error("capture over pending transfer did not set overrun");
	a_overrun_read: assert property (rd_irq && r.prdata[0] && !cap |=> !r.ovr_f)
		else $error("status read did not clear overrun");
	a_sync_gain: assert property (bit_en && !r.sync && !d_err && r.match_cnt == 6'h2F
		&& !resync |=> r.sync && r.sync_f)
		else $error("48 clean bits did not give sync");
	a_no_count_unsync: assert property (!r.sync && !cap |=> $stable(r.bitcnt) && $stable(r.errcnt))
		else $error("counter moved while out of sync");
	a_err_saturate: assert property (r.errcnt == 32'hFFFFFFFF && !cap |=> r.errcnt == 32'hFFFFFFFF)
		else $error("error counter wrapped");
	a_err_unsynced: assert property (!r.sync && !r.be_f |=> !r.be_f)
		else $error("bit error flagged out of sync");
	a_manual_resync: assert property (resync |=> !r.sync ##1 !r.sync)
		else $error("manual resync did not drop sync");
	a_tx_invert: assert property (bit_en && !err_ins
		|=> tx_data_out == ($past(g_bit) ^ $past(r.ctrl[PGD_CTRL_TRANSMIT_INVERT])))
		else $error("transmit bit not generated bit xor invert");

	// ----------------------------------------------------------------
	// Flag, counter and interrupt checks
	// ----------------------------------------------------------------
	// Read-clear checks leave out cycles where a new event may set the flag again
	a_sync_flag_set: assert property (!$stable(r.sync) |-> r.sync_f)
		else $error("sync change did not set sync change flag");
	a_berr_flag_set: assert property (bit_en && r.sync && d_err |=> r.be_f)
		else $error("synced bit error did not set bit error flag");
	a_sync_read_clr: assert property (rd_irq && r.prdata[3] && !bit_en && !resync
		|=> !r.sync_f)
		else $error("status read did not clear sync change flag");
	a_berr_read_clr: assert property (rd_irq && r.prdata[2] && !bit_en
		|=> !r.be_f)
		else $error("status read did not clear bit error flag");
	a_xfer_read_clr: assert property (rd_irq && r.prdata[1] && !cap
		|=> !r.xfer_f)
		else $error("status read did not clear transfer flag");
	a_irq_sync_gate: assert property (r.sync_f && r.ien[PGD_IEN_SYNC] |-> irq_out)
		else $error("sync change flag with enable did not raise interrupt");
	a_irq_berr_gate: assert property (r.be_f && r.ien[PGD_IEN_BERR] |-> irq_out)
		else $error("bit error flag with enable did not raise interrupt");
	a_loss_auto: assert property (bit_en && r.sync && loss
		&& r.win_cnt == PGD_WIN_BITS - 6'h01 |=> !r.sync)
		else $error("too many window errors did not drop sync");
	a_loss_auto_off: assert property (r.sync && !r.ctrl[PGD_CTRL_AUTO] && !resync |=> r.sync)
		else $error("sync dropped with auto resync off");
	a_window_wrap: assert property (bit_en && r.sync && r.win_cnt == PGD_WIN_BITS - 6'h01
		|=> r.win_cnt == 6'h00 && r.win_err == 4'h0)
		else $error("error window did not restart");
	a_count_synced: assert property (bit_en && r.sync && !cap && r.bitcnt != 32'hFFFFFFFF
		|=> r.bitcnt == $past(r.bitcnt) + 32'h00000001)
		else $error("bit counter did not advance while synced");
	a_err_count: assert property (bit_en && r.sync && d_err && !cap
		&& r.errcnt != 32'hFFFFFFFF |=> r.errcnt == $past(r.errcnt) + 32'h00000001)
		else $error("error counter did not advance on synced error");
	a_bit_saturate: assert property (r.bitcnt == 32'hFFFFFFFF && !cap
		|=> r.bitcnt == 32'hFFFFFFFF)
		else $error("bit counter wrapped");
	a_hold_capture: assert property (cap |=> r.hold_pat == $past(r.rxpat)
		&& r.hold_err == $past(r.errcnt) && r.hold_bit == $past(r.bitcnt))
		else $error("capture did not load holding registers");
	a_ovr_only_cap: assert property (!r.ovr_f && !(cap && r.xfer_f) |=> !r.ovr_f)
		else $error("overrun set without capture over pending transfer");

	// ----------------------------------------------------------------
	// Stream and register checks
	// ----------------------------------------------------------------
	a_tx_hold: assert property (!bit_en |=> $stable(tx_data_out))
		else $error("transmit bit changed between bit strobes");
	a_single_error: assert property (bit_en && r.ins_pend
		|=> tx_data_out != ($past(g_bit) ^ $past(r.ctrl[PGD_CTRL_TRANSMIT_INVERT])))
		else $error("single error was not inserted");
	a_single_once: assert property (bit_en && r.ins_pend && !ev_edge |=> !r.ins_pend)
		else $error("single error still pending after insertion");
	a_rate_insert: assert property (bit_en && rate_hit
		|=> tx_data_out != ($past(g_bit) ^ $past(r.ctrl[PGD_CTRL_TRANSMIT_INVERT])))
		else $error("rate error was not inserted");
	a_rate_restart: assert property (bit_en && rate_hit |=> r.rate_cnt == 24'h000000)
		else $error("rate counter did not restart after insertion");
	a_zero_force: assert property (r.ctrl[PGD_CTRL_QRSS] && r.gen[PGD_ZRUN-1:0] == '0
		|-> g_bit)
		else $error("zero run did not force a one");
	a_rep_plain: assert property (!r.ctrl[PGD_CTRL_QRSS] && r.ctrl[PGD_CTRL_PTYPE]
		|-> g_bit == r.gen[r.len])
		else $error("repetitive bit not taken from last stage");
	a_prbs_tap: assert property (!r.ctrl[PGD_CTRL_QRSS] && !r.ctrl[PGD_CTRL_PTYPE]
		|-> g_bit == (r.gen[r.len] ^ r.gen[r.tap]))
		else $error("pseudo-random bit not last stage xor tap");
	a_seed_load: assert property (wr && idx == PGD_REG_SEED3
		|=> r.gen == {$past(pwdata_in[7:0]), $past(r.seed[23:0])})
		else $error("fourth seed byte did not load generator");
	a_rx_invert: assert property (bit_en
		|=> r.rxpat[0] == ($past(r.rx_sync) ^ $past(r.ctrl[PGD_CTRL_RECEIVE_INVERT])))
		else $error("received bit not inverted as selected");
	a_ctrl_write: assert property (wr && idx == PGD_REG_CTRL
		|=> r.ctrl == $past(pwdata_in[7:0]))
		else $error("control write did not land");
	a_len_write: assert property (wr && idx == PGD_REG_LEN
		|=> r.len == $past(pwdata_in[4:0]))
		else $error("length write did not land");
	a_tap_write: assert property (wr && idx == PGD_REG_TAP
		|=> r.tap == $past(pwdata_in[4:0]))
		else $error("tap write did not land");
	a_ien_write: assert property (wr && idx == PGD_REG_IRQ
		|=> r.ien == $past(pwdata_in[7:PGD_IRQ_EN_LO]))
		else $error("interrupt enable write did not land");
endmodule : pgd_pattern_gen_detect

// file: verification/pgd_line_loop.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Far-end loopback: the remote unit returns the line one clock later
// ----------------------------------------------------------------
module pgd_line_loop (
	input wire logic mclk_in, // Line clock
	input wire logic rst_b_in, // Asynchronous reset, active low
	input wire logic tx_in, // Bit sent by the block
	output logic rx_out // Bit returned to the block
);
	// A real loop adds delay, so the returned bit is never combinational
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rx_out <= 1'b0;
		end else begin
			rx_out <= tx_in;
		end
	end
endmodule : pgd_line_loop

// file: verification/pgd_pattern_gen_detect_tb.sv
`timescale 1ns/10ps
module pgd_pattern_gen_detect_tb;
	import pgd_pkg::*;
	logic mclk_in, rst_b_in, psel_in, penable_in, pwrite_in, rx_data_in;
	logic [9:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, d, pat;
	logic pready_out, pslverr_out, tx_data_out, bit_en_out, irq_out, last_err;
	logic [7:0] s;
	int n_fail, cmp_count, i;
	pgd_pattern_gen_detect #(.BIT_DIV(2)) dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .rx_data_in(rx_data_in), .tx_data_out(tx_data_out),
		.bit_en_out(bit_en_out), .irq_out(irq_out));
	pgd_line_loop far_end (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .tx_in(tx_data_out),
		.rx_out(rx_data_in));
	initial begin
		mclk_in = 1'b0;
		forever #50 mclk_in = ~mclk_in;
	end
	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		psel_in <= 1'b1;
		pwrite_in <= wr;
		paddr_in <= {idx, 2'b00};
		pwdata_in <= wd;
		@(posedge mclk_in);
		penable_in <= 1'b1;
		do begin
			@(posedge mclk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 50);
		if (pready_out !== 1'b1) begin
			n_fail++;
			$display("[ERR] %0t no ready from slave", $time);
		end
		d = prdata_out;
		last_err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		@(posedge mclk_in);
	endtask : apb
	task wr(input logic [7:0] idx, input logic [7:0] v);
		apb(1'b1, idx, {24'h000000, v});
	endtask : wr
	task rd(input logic [7:0] idx);
		apb(1'b0, idx, 32'h00000000);
	endtask : rd
	task rd4(output logic [31:0] v);
		for (int k = 0; k < 4; k++) begin
			rd(PGD_REG_DET0 + 8'(k));
			v[8*k+:8] = d[7:0];
		end
	endtask : rd4
	task chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		cmp_count++;
		if (!(got >= lo && got <= hi) || $isunknown(got)) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h..%h", $time, got, lo, hi);
		end
	endtask : chk
	task wait_bits(input int n);
		int k;
		k = 0;
		while (k < n) begin
			@(posedge mclk_in);
			if (bit_en_out === 1'b1) k++;
		end
	endtask : wait_bits
	task end_sim;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_sim
	// Whole sequence is under 5000 clocks; the limit leaves wide margin
	initial begin
		#3000000;
		n_fail++;
		end_sim();
	end
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		n_fail = 0;
		cmp_count = 0;
		rst_b_in = 1'b0;
		{psel_in, penable_in, pwrite_in} = 3'h0;
		paddr_in = 10'h000;
		pwdata_in = 32'h00000000;
		repeat (4) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		rd(PGD_REG_CTRL); chk(d, 32'h02, 32'h02);
		rd(PGD_REG_IRQ); chk(d, 32'h00, 32'h00);
		rd(8'h10); chk({31'h0, last_err}, 32'h1, 32'h1);
		chk(d, 32'h00, 32'h00);
		$display("test reset done");
		wr(PGD_REG_CTRL, 8'h02);
		wr(PGD_REG_LEN, 8'h0E);
		wr(PGD_REG_TAP, 8'h0D);
		wr(PGD_REG_IRQ, 8'hE0);
		for (i = 0; i < 4; i++) wr(PGD_REG_SEED0 + 8'(i), 8'hFF);
		wait_bits(200);
		chk({31'h0, irq_out}, 32'h1, 32'h1);
		rd(PGD_REG_IRQ); chk(d, 32'hF8, 32'hF8);
		rd(PGD_REG_IRQ); chk(d, 32'hF0, 32'hF0);
		chk({31'h0, irq_out}, 32'h0, 32'h0);
		$display("test sync done");
		wr(PGD_REG_UPDATE, 8'h00);
		wr(PGD_REG_DET0, 8'h00);
		rd(PGD_REG_IRQ); chk(d, 32'hF3, 32'hF3);
		rd(PGD_REG_IRQ); chk(d, 32'hF0, 32'hF0);
		wr(PGD_REG_UPDATE, 8'h00);
		wr(PGD_REG_EINS, 8'h08);
		wait_bits(100);
		wr(PGD_REG_UPDATE, 8'h00);
		rd(PGD_REG_IRQ); chk(d, 32'hF7, 32'hF7);
		wr(PGD_REG_CTRL, 8'h82);
		rd4(d); chk(d, 32'h1, 32'h1);
		wr(PGD_REG_CTRL, 8'hC2);
		rd4(d); chk(d, 32'h64, 32'h6C);
		$display("test capture done");
		wr(PGD_REG_EINS, 8'h01);
		wr(PGD_REG_UPDATE, 8'h00);
		wait_bits(200);
		wr(PGD_REG_UPDATE, 8'h00);
		wr(PGD_REG_EINS, 8'h00);
		wr(PGD_REG_CTRL, 8'h82);
		rd4(d); chk(d, 32'h12, 32'h16);
		rd(PGD_REG_IRQ); chk({31'h0, d[4]}, 32'h1, 32'h1);
		$display("test rate done");
		wr(PGD_REG_CTRL, 8'h0A);
		wait_bits(300);
		rd(PGD_REG_IRQ); chk({30'h0, d[4:3]}, 32'h1, 32'h1);
		wr(PGD_REG_CTRL, 8'h0E);
		wait_bits(300);
		rd(PGD_REG_IRQ); chk({30'h0, d[4:3]}, 32'h3, 32'h3);
		wr(PGD_REG_CTRL, 8'h0C);
		wr(PGD_REG_CTRL, 8'h04);
		wait_bits(300);
		rd(PGD_REG_IRQ); chk({31'h0, d[4]}, 32'h1, 32'h1);
		wr(PGD_REG_CTRL, 8'h05);
		wait_bits(300);
		rd(PGD_REG_IRQ); chk({31'h0, d[4]}, 32'h0, 32'h0);
		$display("test resync done");
		wr(PGD_REG_CTRL, 8'h10);
		wr(PGD_REG_LEN, 8'h03);
		wr(PGD_REG_SEED0, 8'h0C);
		for (i = 1; i < 4; i++) wr(PGD_REG_SEED0 + 8'(i), 8'h00);
		wait_bits(8);
		for (i = 0; i < 8; i++) begin
			wait_bits(1);
			s = {s[6:0], tx_data_out};
		end
		chk({30'h0, s[7:4] === s[3:0], s[3:2] !== s[1:0]}, 32'h3, 32'h3);
		$display("test repeat done");
		wait_bits(24);
		wr(PGD_REG_UPDATE, 8'h00);
		rd4(pat);
		chk({30'h0, pat[31:4] === pat[27:0], pat[3:2] !== pat[1:0]}, 32'h3, 32'h3);
		wr(PGD_REG_CTRL, 8'h50);
		rd4(d); chk(d, pat, pat);
		$display("test readout done");
		wr(PGD_REG_CTRL, 8'h30);
		for (i = 0; i < 4; i++) wr(PGD_REG_SEED0 + 8'(i), 8'h00);
		wait_bits(4);
		chk({31'h0, tx_data_out}, 32'h1, 32'h1);
		wr(PGD_REG_CTRL, 8'h10);
		wait_bits(4);
		chk({31'h0, tx_data_out}, 32'h0, 32'h0);
		$display("test suppression done");
		end_sim();
	end
endmodule : pgd_pattern_gen_detect_tb
